// *** src/ext_bus_pkg.sv ***
// Constants shared by the external bus wait controller.
package ext_bus_pkg;

   // ----------------------------------------------------------
   // Widths
   // ----------------------------------------------------------
   localparam int PHYS_W    = 20;
   localparam int LOGICAL_W = 16;
   localparam int CTRL_W    = 8;
   localparam int CNT_W     = 2;

   // ----------------------------------------------------------
   // Wait selection field in the first system control register
   // ----------------------------------------------------------
   localparam int WSEL_LSB = 6;
   localparam int WSEL_MSB = 7;

   localparam logic [1:0] WSEL_SLOW_A = 2'h0;
   localparam logic [1:0] WSEL_SLOW_B = 2'h1;
   localparam logic [1:0] WSEL_MIXED  = 2'h2;
   localparam logic [1:0] WSEL_FAST   = 2'h3;

   // ----------------------------------------------------------
   // Physical memory regions
   // ----------------------------------------------------------
   localparam logic [PHYS_W-1:0] LOW_END  = 20'h7ffff;
   localparam logic [PHYS_W-1:0] HIGH_END = 20'hffdff;

   // ----------------------------------------------------------
   // Wait state counts
   // ----------------------------------------------------------
   localparam logic [CNT_W-1:0] WAITS_NONE = 2'h0;
   localparam logic [CNT_W-1:0] WAITS_ONE  = 2'h1;
   localparam logic [CNT_W-1:0] WAITS_TWO  = 2'h2;

   // ----------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------
   localparam logic [PHYS_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;
   localparam logic [2:0]        SYNC_RST = 3'h7;

   // Cycle controller states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_WAIT  = 4'h2,
      ST_READY = 4'h4,
      ST_HOLD  = 4'h8
   } cyc_state_e;

endpackage

// *** src/ext_bus_wait_ctrl.sv ***
// External bus interface with a programmable wait state controller.
// How it works
// - Wait selection comes from bits 6 and 7 of the first control register.
// - External strobes stay high for internal peripherals and internal RAM.
// - Codes 00 and 01 give one wait per memory region, two for I/O.
// - Code 10 gives low 1, high 0, I/O 1; code 11 gives 0, 0, 1.
// - Codes 00 and 01 widen memory write strobes in both regions.
// - Four core strobes become four external asynchronous strobes.
// - Internal wait request and external ready merge into core wait input.
// - Internal memory always runs with zero waits.
// - Zero wait external memory access ignores external ready.
// - The 1MB space is two halves with independent wait timing.
// - Core memory read strobe stays low for the whole read.
// - Core memory write strobe stays low for the whole write.
// - I/O read strobe is low for at least two clocks.
// - I/O write strobe is low for at least two clocks.
// - While wait is low the core waits; a slow party holds the request.
module ext_bus_wait_ctrl (
   input  wire logic                          CLK,
   input  wire logic                          RST_N,
   input  wire logic [ext_bus_pkg::CTRL_W-1:0] SYSTEM_CONTROL_FIRST,
   input  wire logic [ext_bus_pkg::LOGICAL_W-1:0] LOGICAL_ADDR,
   input  wire logic [ext_bus_pkg::PHYS_W-1:0] PHYS_ADDR,
   input  wire logic                          INTERNAL_HIT,
   input  wire logic                          CORE_MEM_READ_N,
   input  wire logic                          CORE_MEM_WRITE_N,
   input  wire logic                          CORE_IO_READ_N,
   input  wire logic                          CORE_IO_WRITE_N,
   input  wire logic                          EXT_READY_IN,
   output logic                               CORE_WAIT_N,
   output logic [ext_bus_pkg::PHYS_W-1:0]     EXT_ADDR,
   output logic                               EXT_MEM_READ_STROBE_N,
   output logic                               EXT_MEM_WRITE_STROBE_N,
   output logic                               EXT_IO_READ_STROBE_N,
   output logic                               EXT_IO_WRITE_STROBE_N
);

   // ----------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------
   logic       mem_rd;
   logic       mem_wr;
   logic       io_rd;
   logic       io_wr;
   logic       mem_any;
   logic       io_any;
   logic       ext_mem;
   logic       ext_io;
   logic       ext_any;
   logic       high_half;
   logic [1:0] wsel;
   logic       wide;
   logic [ext_bus_pkg::CNT_W-1:0] waits;

   // Strobes are active low; the map decides whether a cycle leaves the chip.
   always_comb begin
      mem_rd    = !CORE_MEM_READ_N;
      mem_wr    = !CORE_MEM_WRITE_N;
      io_rd     = !CORE_IO_READ_N;
      io_wr     = !CORE_IO_WRITE_N;
      mem_any   = mem_rd || mem_wr;
      io_any    = io_rd || io_wr;
      ext_mem   = mem_any && !INTERNAL_HIT
                  && (PHYS_ADDR <= ext_bus_pkg::HIGH_END);
      ext_io    = io_any && !INTERNAL_HIT;
      ext_any   = ext_mem || ext_io;
      high_half = PHYS_ADDR > ext_bus_pkg::LOW_END;
      wsel      = SYSTEM_CONTROL_FIRST[ext_bus_pkg::WSEL_MSB:ext_bus_pkg::WSEL_LSB];
      wide      = !wsel[1] && ext_mem;
   end

   // Wait count per region and selection code.
   always_comb begin
      waits = ext_bus_pkg::WAITS_NONE;
      if (ext_io) begin
         if (!wsel[1]) begin
            waits = ext_bus_pkg::WAITS_TWO;
         end else begin
            waits = ext_bus_pkg::WAITS_ONE;
         end
      end else if (ext_mem) begin
         if (!wsel[1]) begin
            waits = ext_bus_pkg::WAITS_ONE;
         end else if (wsel == ext_bus_pkg::WSEL_MIXED && !high_half) begin
            waits = ext_bus_pkg::WAITS_ONE;
         end else begin
            waits = ext_bus_pkg::WAITS_NONE;
         end
      end
   end

   // ----------------------------------------------------------
   // External ready synchroniser
   // ----------------------------------------------------------
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic       rdy_q;
   logic       rdy_d;

   // Ready changes only once the second and third stages agree.
   always_comb begin
      sync_d = {sync_q[1:0], EXT_READY_IN};
      rdy_d  = rdy_q;
      if (sync_q[1] == sync_q[2]) begin
         rdy_d = sync_q[2];
      end
   end

   // Registers the ready pipeline.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync_q <= ext_bus_pkg::SYNC_RST;
         rdy_q  <= 1'b1;
      end else begin
         sync_q <= sync_d;
         rdy_q  <= rdy_d;
      end
   end

   // ----------------------------------------------------------
   // Cycle controller
   // ----------------------------------------------------------
   ext_bus_pkg::cyc_state_e state_q;
   ext_bus_pkg::cyc_state_e state_d;
   logic [ext_bus_pkg::CNT_W-1:0] cnt_q;
   logic [ext_bus_pkg::CNT_W-1:0] cnt_d;
   logic start;
   logic wait_req;

   // Counts programmed waits, then waits for ready, then holds to the end.
   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      start    = 1'b0;
      wait_req = 1'b0;
      case (state_q)
         ext_bus_pkg::ST_IDLE: begin
            if (ext_any) begin
               start = 1'b1;
               if (waits == ext_bus_pkg::WAITS_NONE) begin
                  state_d = ext_bus_pkg::ST_HOLD;
               end else begin
                  wait_req = 1'b1;
                  cnt_d    = waits - ext_bus_pkg::WAITS_ONE;
                  if (waits == ext_bus_pkg::WAITS_ONE) begin
                     state_d = ext_bus_pkg::ST_READY;
                  end else begin
                     state_d = ext_bus_pkg::ST_WAIT;
                  end
               end
            end
         end
         ext_bus_pkg::ST_WAIT: begin
            wait_req = 1'b1;
            cnt_d    = cnt_q - ext_bus_pkg::WAITS_ONE;
            if (cnt_q == ext_bus_pkg::WAITS_ONE) begin
               state_d = ext_bus_pkg::ST_READY;
            end
         end
         ext_bus_pkg::ST_READY: begin
            if (!rdy_q) begin
               wait_req = 1'b1;
            end else begin
               state_d = ext_bus_pkg::ST_HOLD;
            end
         end
         ext_bus_pkg::ST_HOLD: begin
            if (!mem_any && !io_any) begin
               state_d = ext_bus_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = ext_bus_pkg::ST_IDLE;
         end
      endcase
   end

   // Registers the cycle controller.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_q <= ext_bus_pkg::ST_IDLE;
         cnt_q   <= ext_bus_pkg::CNT_RST;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Merged wait goes straight to the core so it is seen in the same cycle.
   assign CORE_WAIT_N = !wait_req;

   // ----------------------------------------------------------
   // External strobes and address
   // ----------------------------------------------------------
   logic wr_seen_q;
   logic wr_seen_d;
   logic mrd_n_q;
   logic mrd_n_d;
   logic mwr_n_q;
   logic mwr_n_d;
   logic core_io_read_n_n_q;
   logic core_io_read_n_n_d;
   logic core_io_write_n_n_q;
   logic core_io_write_n_n_d;
   logic [ext_bus_pkg::PHYS_W-1:0] addr_q;
   logic [ext_bus_pkg::PHYS_W-1:0] addr_d;

   // Strobes follow the core strobes for external cycles only; a normal
   // write strobe starts one clock late so the address settles first.
   always_comb begin
      wr_seen_d = ext_mem && mem_wr;
      mrd_n_d   = !(ext_mem && mem_rd);
      mwr_n_d   = !(ext_mem && mem_wr && (wide || wr_seen_q));
      core_io_read_n_n_d  = !(ext_io && io_rd);
      core_io_write_n_n_d  = !(ext_io && io_wr);
      addr_d    = addr_q;
      if (start) begin
         addr_d = PHYS_ADDR;
      end
   end

   // Registers the strobes and the bus address.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wr_seen_q <= 1'b0;
         mrd_n_q   <= 1'b1;
         mwr_n_q   <= 1'b1;
         core_io_read_n_n_q  <= 1'b1;
         core_io_write_n_n_q  <= 1'b1;
         addr_q    <= ext_bus_pkg::ADDR_RST;
      end else begin
         wr_seen_q <= wr_seen_d;
         mrd_n_q   <= mrd_n_d;
         mwr_n_q   <= mwr_n_d;
         core_io_read_n_n_q  <= core_io_read_n_n_d;
         core_io_write_n_n_q  <= core_io_write_n_n_d;
         addr_q    <= addr_d;
      end
   end

   // Outputs come straight from the flip-flops.
   assign EXT_MEM_READ_STROBE_N  = mrd_n_q;
   assign EXT_MEM_WRITE_STROBE_N = mwr_n_q;
   assign EXT_IO_READ_STROBE_N   = core_io_read_n_n_q;
   assign EXT_IO_WRITE_STROBE_N  = core_io_write_n_n_q;
   assign EXT_ADDR               = addr_q;

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // Two consecutive wait requests.
   sequence s_two_waits;
      !CORE_WAIT_N ##1 !CORE_WAIT_N;
   endsequence

   // Start of an I/O access under a slow code.
   sequence s_slow_io_start;
      start && ext_io && !wsel[1];
   endsequence

   // Normal write strobe: high for the first clock, then low.
   sequence s_late_write;
      EXT_MEM_WRITE_STROBE_N ##1 !EXT_MEM_WRITE_STROBE_N;
   endsequence

   property p_sel_field;
      start && ext_mem && wsel == ext_bus_pkg::WSEL_FAST |-> CORE_WAIT_N;
   endproperty
   a_sel_field: assert property (p_sel_field) else $error("fast code waited");

   property p_internal_quiet;
      (mem_any || io_any) && INTERNAL_HIT |=> EXT_MEM_READ_STROBE_N
         && EXT_MEM_WRITE_STROBE_N && EXT_IO_READ_STROBE_N && EXT_IO_WRITE_STROBE_N;
   endproperty
   a_internal_quiet: assert property (p_internal_quiet) else $error("strobe on internal");

   property p_slow_io;
      s_slow_io_start |-> s_two_waits;
   endproperty
   a_slow_io: assert property (p_slow_io) else $error("slow I/O lacks two waits");

   property p_mixed_high;
      start && ext_mem && high_half && wsel[1] |-> CORE_WAIT_N;
   endproperty
   a_mixed_high: assert property (p_mixed_high) else $error("high half waited");

   property p_wide_write;
      start && ext_mem && mem_wr && !wsel[1] |=> !EXT_MEM_WRITE_STROBE_N;
   endproperty
   a_wide_write: assert property (p_wide_write) else $error("write not widened");

   property p_read_strobe;
      ext_mem && mem_rd |=> !EXT_MEM_READ_STROBE_N;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing");

   property p_ready_merge;
      state_q == ext_bus_pkg::ST_READY && !rdy_q |-> !CORE_WAIT_N;
   endproperty
   a_ready_merge: assert property (p_ready_merge) else $error("ready not merged");

   property p_internal_zero;
      (mem_any || io_any) && INTERNAL_HIT |-> CORE_WAIT_N;
   endproperty
   a_internal_zero: assert property (p_internal_zero) else $error("internal waited");

   property p_ignore_ready;
      start && waits == ext_bus_pkg::WAITS_NONE |=> CORE_WAIT_N;
   endproperty
   a_ignore_ready: assert property (p_ignore_ready) else $error("zero wait stalled");

   property p_io_rd_len;
      $fell(EXT_IO_READ_STROBE_N) |-> (ext_io && io_rd) ##1 !EXT_IO_READ_STROBE_N;
   endproperty
   a_io_rd_len: assert property (p_io_rd_len) else $error("I/O read too short");

   property p_io_wr_len;
      $fell(EXT_IO_WRITE_STROBE_N) |-> ##1 !EXT_IO_WRITE_STROBE_N;
   endproperty
   a_io_wr_len: assert property (p_io_wr_len) else $error("I/O write too short");

   property p_one_wait;
      start && waits == ext_bus_pkg::WAITS_ONE && rdy_q && rdy_d
         |-> !CORE_WAIT_N ##1 CORE_WAIT_N;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait count wrong");

   property p_low_half_waits;
      start && ext_mem && !high_half && wsel == ext_bus_pkg::WSEL_MIXED |-> !CORE_WAIT_N;
   endproperty
   a_low_half_waits: assert property (p_low_half_waits) else $error("low half no wait");

   property p_write_held;
      ext_mem && mem_wr && $past(ext_mem) && $past(mem_wr) |=> !EXT_MEM_WRITE_STROBE_N;
   endproperty
   a_write_held: assert property (p_write_held) else $error("write strobe dropped");

   property p_normal_write;
      start && ext_mem && mem_wr && wsel[1] ##1 ext_mem && mem_wr |-> s_late_write;
   endproperty
   a_normal_write: assert property (p_normal_write) else $error("normal write early");

   property p_addr_load;
      start |=> EXT_ADDR == $past(PHYS_ADDR);
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("bus address not loaded");

endmodule

// *** tb/ext_mem_model.sv ***
// Behavioural model of a slow external memory or I/O device.
module ext_mem_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] strobes_n,
   input  wire logic [7:0] slow,
   output logic            ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] busy_q;

   // Counts cycles since any strobe went low; idle between accesses.
   always_ff @(posedge clk) begin
      if (!rst_n || (&strobes_n)) begin
         busy_q <= 8'h00;
      end else if (busy_q != 8'hff) begin
         busy_q <= busy_q + 8'h01;
      end
   end

   // A slow device holds ready low until it has had enough strobe time.
   // Ready is driven at all times, so a slow device idles with ready low.
   assign ready = (busy_q >= slow);
endmodule

// *** tb/external_bus_wait_control_tb_top.sv ***
// Self-checking bench for the external bus wait controller.
module external_bus_wait_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  ctrl = 8'h00;
   logic [19:0] phys = 20'h00000;
   logic        hit = 1'b0;
   logic [3:0]  core_n = 4'hf;
   logic [7:0]  slow = 8'h00;
   logic        ready;
   logic        wait_n;
   logic [19:0] ext_addr;
   logic [3:0]  ext_n;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;

   // Free running 100 MHz clock.
   always #5 clk = ~clk;

   ext_bus_wait_ctrl ext_bus_wait_ctrl_inst (
      .CLK(clk), .RST_N(rst_n), .SYSTEM_CONTROL_FIRST(ctrl), .LOGICAL_ADDR(phys[15:0]),
      .PHYS_ADDR(phys), .INTERNAL_HIT(hit), .CORE_MEM_READ_N(core_n[0]),
      .CORE_MEM_WRITE_N(core_n[1]), .CORE_IO_READ_N(core_n[2]), .CORE_IO_WRITE_N(core_n[3]),
      .EXT_READY_IN(ready), .CORE_WAIT_N(wait_n), .EXT_ADDR(ext_addr),
      .EXT_MEM_READ_STROBE_N(ext_n[0]), .EXT_MEM_WRITE_STROBE_N(ext_n[1]),
      .EXT_IO_READ_STROBE_N(ext_n[2]), .EXT_IO_WRITE_STROBE_N(ext_n[3]));

   ext_mem_model ext_mem_model_inst (
      .clk(clk), .rst_n(rst_n), .strobes_n(ext_n), .slow(slow), .ready(ready));

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Runs one core access; strobe bit kind goes low, released two cycles after wait ends.
   task automatic run(input logic [1:0] code, input int kind, input logic [19:0] addr,
                      input logic intl, output int waits, output int first);
      int  k;
      int  rel;
      logic ext;
      @(negedge clk);
      ctrl = {code, 6'h00};
      phys = addr;
      hit = intl;
      core_n[kind] = 1'b0;
      waits = 0;
      first = -1;
      rel = -1;
      ext = !intl && (addr <= 20'hffdff);
      for (k = 0; k < 60 && !(rel >= 0 && k > rel + 1); k++) begin
         if (k == rel) core_n = 4'hf;
         #2;
         if (rel < 0 && wait_n === 1'b0) waits++;
         else if (rel < 0) rel = k + 2;
         if (ext_n[kind] === 1'b0 && first < 0) first = k;
         if (ext) chk(20'(ext_n | (4'h1 << kind)), 20'hf);
         else chk(20'(ext_n), 20'hf);
         if (ext && k == 1) chk(ext_addr, addr);
         @(negedge clk);
      end
      chk(20'(ext_n), 20'hf);
   endtask

   // Every selection code against both memory halves and I/O, all four strobes.
   task automatic t_wait_table();
      int c;
      int kd;
      int h;
      int w;
      int f;
      int ew;
      logic [19:0] a;
      for (c = 0; c < 4; c++) begin
         for (kd = 0; kd < 4; kd++) begin
            for (h = 0; h < 2; h++) begin
               a = (kd > 1) ? 20'h00042 : (h ? 20'h81234 : 20'h01234);
               ew = (kd > 1) ? ((c < 2) ? 2 : 1) : (h ? ((c < 2) ? 1 : 0) : ((c == 3) ? 0 : 1));
               run(c[1:0], kd, a, 1'b0, w, f);
               chk(20'(w), 20'(ew));
               chk(20'(f), (kd == 1 && c > 1) ? 20'h2 : 20'h1);
            end
         end
      end
      $display("test wait_table done");
   endtask

   // Internal targets never see a strobe or a wait, even with the slowest code.
   task automatic t_internal();
      int w;
      int f;
      run(2'h0, 0, 20'h01234, 1'b1, w, f);
      chk(20'(w), 20'h0);
      run(2'h0, 3, 20'h00042, 1'b1, w, f);
      chk(20'(w), 20'h0);
      run(2'h0, 1, 20'hffe00, 1'b0, w, f);
      chk(20'(w), 20'h0);
      $display("test internal done");
   endtask

   // A slow device stretches the wait past the programmed count, but not forever.
   // The idle low ready level needs a few clocks to pass the synchroniser first.
   task automatic t_slow_ready();
      int w;
      int f;
      slow = 8'h04;
      repeat (6) @(negedge clk);
      run(2'h0, 2, 20'h00042, 1'b0, w, f);
      chk(20'(w > 2 && w <= 12), 20'h1);
      repeat (6) @(negedge clk);
      run(2'h2, 0, 20'h01234, 1'b0, w, f);
      chk(20'(w > 1 && w <= 11), 20'h1);
      run(2'h3, 0, 20'h01234, 1'b0, w, f);
      chk(20'(w), 20'h0);
      run(2'h2, 1, 20'h81234, 1'b0, w, f);
      chk(20'(w), 20'h0);
      slow = 8'h00;
      $display("test slow_ready done");
   endtask

   // A reset in mid-run clears the bus address and leaves the bus quiet.
   task automatic t_reset();
      @(negedge clk);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      chk(ext_addr, ext_bus_pkg::ADDR_RST);
      chk(20'(ext_n), 20'hf);
      chk(20'(wait_n), 20'h1);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      $display("test reset done");
   endtask

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Reset for eight cycles, then the scenarios.
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_wait_table();
      t_reset();
      t_internal();
      t_slow_ready();
      wrap_up();
   end
endmodule
